/* File: src/opbs_top.sv */
`timescale 1ns/1ps
`include "opbs_map.svh"

// Notes on behaviour
// - Status bit 2 shows mode ready, resets 1
// - Mode change clears ready until transition done
// - Status bit 1 shows buffer empty, resets 1
// - Launching address write clears buffer empty
// - Buffer registers ignore writes while request pending
// - Status bit 0 shows programming idle, resets 1
// - Address register holds 13 bits, upper zero
// - Data register holds 32 bits, resets zero
// - Address write launches programming in programming mode
// - Mode codes zero to six as listed
// - Mode field read-only during transition
module opbs_top (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Wishbone classic slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [31:0]            adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic [31:0]                 dat_o,
    output logic                        ack_o,
    output logic                        irq_o,
    // Rest of the controller and cell array
    output opbs_pkg::opbs_mode_type     mode_o,
    output logic                        mode_change_o,
    input  wire logic                   mode_done_i,
    output logic                        programming_mode_valid_o,
    output opbs_pkg::opbs_req_type      programming_mode_req_o,
    input  wire logic                   programming_mode_ready_i,
    input  wire logic                   programming_mode_done_i
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    opbs_pkg::opbs_mode_type mode_q;
    opbs_pkg::opbs_mode_type mode_d;
    opbs_pkg::opbs_eng_type  eng_q;
    opbs_pkg::opbs_eng_type  eng_d;
    opbs_pkg::opbs_req_type  buf_rd;
    opbs_pkg::opbs_bufwr_type bufwr;
    logic                    mrdy_q;
    logic                    mrdy_d;
    logic                    pend_q;
    logic                    pend_d;
    logic                    mchg_q;
    logic                    pvalid_q;
    logic                    ack_q;
    logic [31:0]             rdat_q;
    logic [31:0]             rdat_d;
    logic [2:0]              ist_q;
    logic [2:0]              ist_d;
    logic [2:0]              ien_q;
    logic [2:0]              ien_d;
    logic                    irq_q;
    logic [2:0]              events;
    logic [2:0]              status;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
        return a[31:2] == r[31:2];
    endfunction : hit

    wire access   = cyc_i & stb_i & ~ack_q;
    wire wr       = access & we_i;
    wire sel_mode = hit(adr_i, `OPBS_ADR_MODE);
    wire sel_stat = hit(adr_i, `OPBS_ADR_STATUS);
    wire sel_padr = hit(adr_i, `OPBS_ADR_PADDR);
    wire sel_pdat = hit(adr_i, `OPBS_ADR_PDATA);
    wire sel_ist  = hit(adr_i, `OPBS_ADR_IRQ_STAT);
    wire sel_ien  = hit(adr_i, `OPBS_ADR_IRQ_EN);
    wire sel_iclr = hit(adr_i, `OPBS_ADR_IRQ_CLR);

    // ------------------------------------------------------------------------
    // Mode select
    // ------------------------------------------------------------------------
    wire [2:0] wmode     = dat_i[2:0];
    wire       mode_legal = wmode <= `OPBS_MODE_ACOPY;
    // Mode field writable only when ready, legal code and a real change
    wire       mode_wr   = wr & sel_mode & sel_i[0] & mrdy_q & mode_legal
                           & (wmode != mode_q);
    wire       mode_fin  = ~mrdy_q & mode_done_i;
    wire       in_programming_mode   = (mode_q == opbs_pkg::programming_mode) & mrdy_q;

    // Copy mode drops back to deep standby when the transfer is done
    always_comb begin
        mode_d = mode_q;
        if (mode_wr) begin
            mode_d = opbs_pkg::opbs_mode_type'(wmode);
        end else if (mode_fin && mode_q == opbs_pkg::auto_copy_mode) begin
            mode_d = opbs_pkg::deep_standby_mode;
        end
    end

    // Ready falls on a change and rises when the transition finishes
    assign mrdy_d = mode_wr ? 1'b0 : (mode_fin ? 1'b1 : mrdy_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= opbs_pkg::deep_standby_mode;
            mrdy_q <= `OPBS_RST_MRDY;
            mchg_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            mrdy_q <= mrdy_d;
            mchg_q <= mode_wr;
        end
    end

    // ------------------------------------------------------------------------
    // Program buffer writes
    // ------------------------------------------------------------------------
    // Pending request freezes both buffer registers
    wire buf_open = ~pend_q;
    wire padr_wr  = wr & sel_padr & buf_open;
    wire launch   = padr_wr & in_programming_mode;

    assign bufwr.addr_we = padr_wr;
    assign bufwr.data_we = wr & sel_pdat & buf_open;
    assign bufwr.sel     = sel_i;
    assign bufwr.wdata   = dat_i;

    opbs_program_buffer u_program_buffer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .wr_i  (bufwr),
        .buf_o (buf_rd)
    );

    // ------------------------------------------------------------------------
    // Programming engine
    // ------------------------------------------------------------------------
    wire taken = (eng_q == opbs_pkg::ENG_OFFER) & programming_mode_ready_i;

    // Pending flag: set by a launch, cleared when the engine takes it
    assign pend_d = launch ? 1'b1 : (taken ? 1'b0 : pend_q);

    always_comb begin
        eng_d = eng_q;
        case (eng_q)
            opbs_pkg::ENG_IDLE: begin
                if (pend_q) begin
                    eng_d = opbs_pkg::ENG_OFFER;
                end
            end
            opbs_pkg::ENG_OFFER: begin
                if (programming_mode_ready_i) begin
                    eng_d = opbs_pkg::ENG_BUSY;
                end
            end
            opbs_pkg::ENG_BUSY: begin
                if (programming_mode_done_i) begin
                    eng_d = opbs_pkg::ENG_IDLE;
                end
            end
            default: begin
                eng_d = opbs_pkg::ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eng_q    <= opbs_pkg::ENG_IDLE;
            pend_q   <= 1'b0;
            pvalid_q <= 1'b0;
        end else begin
            eng_q    <= eng_d;
            pend_q   <= pend_d;
            pvalid_q <= (eng_d == opbs_pkg::ENG_OFFER);
        end
    end

    // ------------------------------------------------------------------------
    // Status and interrupt events
    // ------------------------------------------------------------------------
    assign status[`OPBS_ST_MRDY_BIT]  = mrdy_q;
    assign status[`OPBS_ST_EMPTY_BIT] = ~pend_q;
    assign status[`OPBS_ST_IDLE_BIT]  = (eng_q == opbs_pkg::ENG_IDLE) & ~pend_q;

    assign events[`OPBS_EV_PROGRAMMING_MODE_DONE] = (eng_q == opbs_pkg::ENG_BUSY) & programming_mode_done_i;
    assign events[`OPBS_EV_BUF_TAKEN] = taken;
    assign events[`OPBS_EV_MODE_DONE] = mode_fin;

    // Sticky bits, a new event wins over a clear in the same cycle
    wire [2:0] iclr = (wr & sel_iclr & sel_i[0]) ? dat_i[2:0] : 3'h0;
    assign ist_d = (ist_q & ~iclr) | events;
    assign ien_d = (wr & sel_ien & sel_i[0]) ? dat_i[2:0] : ien_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= `OPBS_RST_IRQ;
            ien_q <= `OPBS_RST_IRQ;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            ien_q <= ien_d;
            irq_q <= |(ist_d & ien_d);
        end
    end

    // ------------------------------------------------------------------------
    // Read mux, unmapped and write-only addresses read zero
    // ------------------------------------------------------------------------
    always_comb begin
        if (sel_mode) begin
            rdat_d = {29'h0, mode_q};
        end else if (sel_stat) begin
            rdat_d = {29'h0, status};
        end else if (sel_padr) begin
            rdat_d = {19'h0, buf_rd.addr};
        end else if (sel_pdat) begin
            rdat_d = buf_rd.data;
        end else if (sel_ist) begin
            rdat_d = {29'h0, ist_q};
        end else if (sel_ien) begin
            rdat_d = {29'h0, ien_q};
        end else begin
            rdat_d = 32'h0000_0000;
        end
    end

    // Acknowledge one cycle after the strobe, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= access;
            rdat_q <= (access & ~we_i) ? rdat_d : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign dat_o         = rdat_q;
    assign ack_o         = ack_q;
    assign irq_o         = irq_q;
    assign mode_o        = mode_q;
    assign mode_change_o = mchg_q;
    assign programming_mode_valid_o  = pvalid_q;
    assign programming_mode_req_o    = buf_rd;

endmodule : opbs_top

/* File: common/opbs_map.svh */
`ifndef OPBS_MAP_SVH
`define OPBS_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define OPBS_ADR_MODE        32'h07f4_0000
`define OPBS_ADR_STATUS      32'h07f4_0004
`define OPBS_ADR_PADDR       32'h07f4_0008
`define OPBS_ADR_PDATA       32'h07f4_000c
`define OPBS_ADR_IRQ_STAT    32'h07f4_0040
`define OPBS_ADR_IRQ_EN      32'h07f4_0044
`define OPBS_ADR_IRQ_CLR     32'h07f4_0048

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define OPBS_ST_IDLE_BIT     0
`define OPBS_ST_EMPTY_BIT    1
`define OPBS_ST_MRDY_BIT     2
`define OPBS_MODE_W          3
`define OPBS_PADDR_W         13
`define OPBS_IRQ_W           3
`define OPBS_EV_PROGRAMMING_MODE_DONE    0
`define OPBS_EV_BUF_TAKEN    1
`define OPBS_EV_MODE_DONE    2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OPBS_RST_MRDY        1'h1
`define OPBS_RST_EMPTY       1'h1
`define OPBS_RST_IDLE        1'h1
`define OPBS_RST_PADDR       13'h0000
`define OPBS_RST_PDATA       32'h0000_0000
`define OPBS_RST_IRQ         3'h0

// ----------------------------------------------------------------------------
// Operating mode codes
// ----------------------------------------------------------------------------
`define OPBS_MODE_DEEP_STANDBY_MODE      3'h0
`define OPBS_MODE_STANDBY_MODE       3'h1
`define OPBS_MODE_READ       3'h2
`define OPBS_MODE_PROGRAMMING_MODE       3'h3
`define OPBS_MODE_PROGRAM_VERIFY_MODE       3'h4
`define OPBS_MODE_INITIAL_MARGIN_READ_MODE       3'h5
`define OPBS_MODE_ACOPY      3'h6

`endif

/* File: common/opbs_pkg.sv */
package opbs_pkg;

    // ------------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        deep_standby_mode        = 3'h0,
        standby_mode             = 3'h1,
        normal_read_mode         = 3'h2,
        programming_mode         = 3'h3,
        program_verify_mode      = 3'h4,
        initial_margin_read_mode = 3'h5,
        auto_copy_mode           = 3'h6
    } opbs_mode_type;

    // ------------------------------------------------------------------------
    // Programming engine states, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ENG_IDLE  = 3'b001,
        ENG_OFFER = 3'b010,
        ENG_BUSY  = 3'b100
    } opbs_eng_type;

    // ------------------------------------------------------------------------
    // One programming request held in the program buffer
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [12:0] addr;
        logic [31:0] data;
    } opbs_req_type;

    // ------------------------------------------------------------------------
    // Byte-lane write into the program buffer
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        addr_we;
        logic        data_we;
        logic [3:0]  sel;
        logic [31:0] wdata;
    } opbs_bufwr_type;

endpackage : opbs_pkg

/* File: src/opbs_program_buffer.sv */
`timescale 1ns/1ps
`include "opbs_map.svh"

module opbs_program_buffer (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire opbs_pkg::opbs_bufwr_type wr_i,
    output opbs_pkg::opbs_req_type     buf_o
);

    // ------------------------------------------------------------------------
    // Byte merge
    // ------------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    opbs_pkg::opbs_req_type buf_q;
    opbs_pkg::opbs_req_type buf_d;
    logic [31:0]            addr_wide;

    // Next contents, address kept to 13 bits, upper bits dropped
    assign addr_wide  = merge({19'h0, buf_q.addr}, wr_i.wdata, wr_i.sel);
    assign buf_d.addr = wr_i.addr_we ? addr_wide[12:0] : buf_q.addr;
    assign buf_d.data = wr_i.data_we ? merge(buf_q.data, wr_i.wdata, wr_i.sel) : buf_q.data;

    // Storage, contents read straight from the register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_q.addr <= `OPBS_RST_PADDR;
            buf_q.data <= `OPBS_RST_PDATA;
        end else begin
            buf_q <= buf_d;
        end
    end

    assign buf_o = buf_q;

endmodule : opbs_program_buffer

/* File: tb/opbs_props.sv */
`timescale 1ns/1ps
`include "opbs_map.svh"

module opbs_props (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    cyc_i,
    input wire logic                    stb_i,
    input wire logic                    we_i,
    input wire logic [31:0]             adr_i,
    input wire logic [3:0]              sel_i,
    input wire logic [31:0]             dat_i,
    input wire logic [31:0]             dat_o,
    input wire logic                    ack_o,
    input wire logic                    irq_o,
    input wire opbs_pkg::opbs_mode_type mode_o,
    input wire logic                    mode_change_o,
    input wire logic                    mode_done_i,
    input wire logic                    programming_mode_valid_o,
    input wire opbs_pkg::opbs_req_type  programming_mode_req_o,
    input wire logic                    programming_mode_ready_i,
    input wire logic                    programming_mode_done_i
);
    // ----------------------------
    // Shadow of the status flags
    // ----------------------------
    logic tk;
    logic rd_st;
    logic wr_pa;
    logic launch;
    logic take;
    logic idle;
    logic rdy_q;
    logic emp_q;
    logic eng_q;

    // Request decode
    assign tk     = cyc_i && stb_i && !ack_o;
    assign rd_st  = tk && !we_i && adr_i == `OPBS_ADR_STATUS;
    assign wr_pa  = tk && we_i && adr_i == `OPBS_ADR_PADDR;
    assign launch = wr_pa && mode_o == opbs_pkg::programming_mode && rdy_q && emp_q;
    assign take   = programming_mode_valid_o && programming_mode_ready_i;
    assign idle   = emp_q && !eng_q;

    // Flags as software should see them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_q <= 1'b1;
            emp_q <= 1'b1;
            eng_q <= 1'b0;
        end else begin
            rdy_q <= !mode_change_o && (rdy_q || mode_done_i);
            emp_q <= !launch && (emp_q || take);
            eng_q <= take || (eng_q && !programming_mode_done_i);
        end
    end

    // ----------------------------
    // Properties
    // ----------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ack;
        ack_o ##1 !ack_o;
    endsequence
    // Offer flop loads one edge after the launch edge, so valid is seen on the second edge
    sequence s_offer;
        !programming_mode_valid_o ##1 programming_mode_valid_o;
    endsequence

    property p_ack;
        tk |=> s_ack;
    endproperty
    property p_chg;
        $changed(mode_o) && mode_o != opbs_pkg::deep_standby_mode |-> ##[0:1] mode_change_o;
    endproperty
    property p_hold;
        !rdy_q |-> $stable(mode_o);
    endproperty
    property p_launch;
        launch && !eng_q |=> s_offer;
    endproperty
    property p_store;
        wr_pa && mode_o != opbs_pkg::programming_mode && idle |=> !programming_mode_valid_o [*4];
    endproperty
    property p_ro;
        tk && we_i && !emp_q && (adr_i == `OPBS_ADR_PADDR || adr_i == `OPBS_ADR_PDATA)
            |=> $stable(programming_mode_req_o) [*2];
    endproperty
    property p_rdy;
        rd_st |=> dat_o[2] == $past(rdy_q);
    endproperty
    property p_emp;
        rd_st |=> dat_o[1] == $past(emp_q);
    endproperty
    property p_idle;
        rd_st |=> dat_o[0] == $past(idle);
    endproperty
    property p_pa;
        tk && !we_i && adr_i == `OPBS_ADR_PADDR |=> dat_o[31:13] == 19'h0;
    endproperty

    a_ack: assert property (p_ack) else $error("ack is not one pulse");
    a_chg: assert property (p_chg) else $error("no mode change pulse");
    a_hold: assert property (p_hold) else $error("mode moved in transition");
    a_launch: assert property (p_launch) else $error("launch not offered");
    a_store: assert property (p_store) else $error("offer outside programming_mode mode");
    a_ro: assert property (p_ro) else $error("full buffer was written");
    a_rdy: assert property (p_rdy) else $error("ready flag wrong");
    a_emp: assert property (p_emp) else $error("empty flag wrong");
    a_idle: assert property (p_idle) else $error("idle flag wrong");
    a_pa: assert property (p_pa) else $error("address upper bits set");
endmodule : opbs_props

bind opbs_top opbs_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .mode_o(mode_o),
    .mode_change_o(mode_change_o), .mode_done_i(mode_done_i), .programming_mode_valid_o(programming_mode_valid_o),
    .programming_mode_req_o(programming_mode_req_o), .programming_mode_ready_i(programming_mode_ready_i), .programming_mode_done_i(programming_mode_done_i)
);

/* File: tb/opbs_cell_model.sv */
`timescale 1ns/1ps

module opbs_cell_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic slow_i,
    input  wire logic valid_i,
    input  wire logic chg_i,
    output logic      ready_o,
    output logic      done_o,
    output logic      mdone_o
);
    logic [3:0] wait_q;
    logic [3:0] programming_mode_q;
    logic [3:0] mode_q;

    // Accept offers, promptly or after a stall, then program and settle modes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_q  <= 4'h0;
            programming_mode_q  <= 4'h0;
            mode_q  <= 4'h0;
            ready_o <= 1'b0;
        end else begin
            ready_o <= valid_i && !ready_o && wait_q >= (slow_i ? 4'hc : 4'h0);
            wait_q  <= (valid_i && !ready_o) ? wait_q + 4'h1 : 4'h0;
            programming_mode_q  <= (valid_i && ready_o) ? 4'hc : (programming_mode_q != 4'h0 ? programming_mode_q - 4'h1 : 4'h0);
            mode_q  <= chg_i ? 4'h8 : (mode_q != 4'h0 ? mode_q - 4'h1 : 4'h0);
        end
    end

    // One-cycle completion pulses
    assign done_o  = programming_mode_q == 4'h1;
    assign mdone_o = mode_q == 4'h1;
endmodule : opbs_cell_model

/* File: tb/opbs_top_tb.sv */
`timescale 1ns/1ps
`include "opbs_map.svh"

`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            n_fail++; \
            $display("unexpected at %0t: got %h expected %h", $time, g, e); \
        end \
    end

module opbs_top_tb;
    typedef struct packed {
        logic        w;
        logic [31:0] a;
        logic [31:0] d;
    } opbs_row_type;

    logic                    clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    logic                    cyc   = 1'b0;
    logic                    stb   = 1'b0;
    logic                    we    = 1'b0;
    logic [31:0]             adr   = 32'h0;
    logic [31:0]             wdat  = 32'h0;
    logic                    slow  = 1'b0;
    logic [31:0]             rdat;
    logic [31:0]             dat_o;
    logic                    ack_o;
    logic                    irq_o;
    logic                    chg;
    logic                    mdone;
    logic                    valid;
    logic                    ready;
    logic                    done;
    opbs_pkg::opbs_mode_type mode_o;
    opbs_pkg::opbs_req_type  req;
    int                      n_fail = 0;
    int                      check_count = 0;

    // Register walk: reads give expected data, writes give write data
    opbs_row_type rows [12] = '{
        '{1'b0, `OPBS_ADR_STATUS, 32'h0000_0007}, '{1'b0, `OPBS_ADR_PADDR, 32'h0000_0000},
        '{1'b0, `OPBS_ADR_PDATA, 32'h0000_0000}, '{1'b1, `OPBS_ADR_PDATA, 32'ha5a5_5a5a},
        '{1'b0, `OPBS_ADR_PDATA, 32'ha5a5_5a5a}, '{1'b1, `OPBS_ADR_PADDR, 32'hffff_ffff},
        '{1'b0, `OPBS_ADR_PADDR, 32'h0000_1fff}, '{1'b0, `OPBS_ADR_STATUS, 32'h0000_0007},
        '{1'b0, 32'h07f4_0020, 32'h0000_0000}, '{1'b1, `OPBS_ADR_STATUS, 32'h0000_0000},
        '{1'b0, `OPBS_ADR_STATUS, 32'h0000_0007}, '{1'b0, `OPBS_ADR_IRQ_CLR, 32'h0000_0000}
    };

    always #20 clk_i = ~clk_i;

    opbs_top DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .mode_o(mode_o),
        .mode_change_o(chg), .mode_done_i(mdone), .programming_mode_valid_o(valid), .programming_mode_req_o(req),
        .programming_mode_ready_i(ready), .programming_mode_done_i(done)
    );
    opbs_cell_model u_cell (
        .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .valid_i(valid), .chg_i(chg),
        .ready_o(ready), .done_o(done), .mdone_o(mdone)
    );

    // Verdict and end of run
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // One classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            test_done();
        end
    endtask : wb

    // Poll status until it shows the wanted flags
    task automatic wait_st(input logic [2:0] v);
        int n;
        n = 0;
        do begin
            wb(1'b0, `OPBS_ADR_STATUS, 32'h0);
            n++;
        end while (rdat[2:0] !== v && n < 50);
        `CHK(rdat[2:0], v)
        // A poll that runs out of tries has counted its mismatch and ends the run
        if (rdat[2:0] !== v)
            test_done();
    endtask : wait_st

    initial begin : main
        int i;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHK(mode_o, opbs_pkg::deep_standby_mode)
        for (i = 0; i < 12; i++) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                `CHK(rdat, rows[i].d)
        end
        $display("test registers done");
        for (i = 1; i < 7; i++) begin
            wb(1'b1, `OPBS_ADR_MODE, 32'(i));
            `CHK(mode_o, opbs_pkg::opbs_mode_type'(i))
            wb(1'b0, `OPBS_ADR_STATUS, 32'h0);
            `CHK(rdat[2], 1'b0)
            wb(1'b1, `OPBS_ADR_MODE, 32'h0);
            `CHK(mode_o, opbs_pkg::opbs_mode_type'(i))
            wait_st(3'h7);
            if (i == 6)
                `CHK(mode_o, opbs_pkg::deep_standby_mode)
        end
        wb(1'b1, `OPBS_ADR_MODE, 32'h7);
        `CHK(mode_o, opbs_pkg::deep_standby_mode)
        wb(1'b1, `OPBS_ADR_MODE, 32'h3);
        wait_st(3'h7);
        $display("test modes done");
        slow <= 1'b1;
        wb(1'b1, `OPBS_ADR_PDATA, 32'hc3c3_3c3c);
        wb(1'b1, `OPBS_ADR_PADDR, 32'h0000_1abc);
        wb(1'b0, `OPBS_ADR_STATUS, 32'h0);
        `CHK(rdat[2:0], 3'h4)
        wb(1'b1, `OPBS_ADR_PDATA, 32'h1111_1111);
        wb(1'b1, `OPBS_ADR_PADDR, 32'h0000_0222);
        wb(1'b0, `OPBS_ADR_PDATA, 32'h0);
        `CHK(rdat, 32'hc3c3_3c3c)
        wait_st(3'h6);
        `CHK(req, {13'h1abc, 32'hc3c3_3c3c})
        slow <= 1'b0;
        wb(1'b1, `OPBS_ADR_PDATA, 32'h0f0f_0f0f);
        wb(1'b1, `OPBS_ADR_PADDR, 32'h0000_0000);
        wait_st(3'h7);
        `CHK(req, {13'h0000, 32'h0f0f_0f0f})
        $display("test programming done");
        wb(1'b0, `OPBS_ADR_IRQ_STAT, 32'h0);
        `CHK(rdat, 32'h0000_0007)
        `CHK(irq_o, 1'b0)
        wb(1'b1, `OPBS_ADR_IRQ_EN, 32'h2);
        @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        wb(1'b1, `OPBS_ADR_IRQ_CLR, 32'h2);
        @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        wb(1'b0, `OPBS_ADR_IRQ_STAT, 32'h0);
        `CHK(rdat, 32'h0000_0005)
        $display("test interrupts done");
        slow <= 1'b1;
        wb(1'b1, `OPBS_ADR_PDATA, 32'h5555_aaaa);
        wb(1'b1, `OPBS_ADR_PADDR, 32'h0000_0001);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHK(mode_o, opbs_pkg::deep_standby_mode)
        wb(1'b0, `OPBS_ADR_STATUS, 32'h0);
        `CHK(rdat, 32'h0000_0007)
        wb(1'b0, `OPBS_ADR_PADDR, 32'h0);
        `CHK(rdat, 32'h0000_0000)
        $display("test reset done");
        test_done();
    end
endmodule : opbs_top_tb
